// >>> verilog/sei2c_slave.sv
`include "sei2c_regs.svh"
module sei2c_slave #(
    parameter logic [4:0] DEV_PREFIX = 5'h0b, // arbitrary value
    parameter int ADDR_W = `SEI2C_ADDR_W,
    parameter int PAGE_BITS = `SEI2C_PAGE_BITS
) (
    // system side
    input wire logic mclk,
    input wire logic rstn,
    // link side
    input wire logic lclk,
    sei2c_if.dev bus,
    // hardwired select straps
    input wire logic select_pin_high,
    input wire logic select_pin_low,
    // write notification, mclk domain
    output logic wr_valid,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [7:0] wr_data
);
    localparam int WORDS = 1 << ADDR_W;

    if (ADDR_W < 9 || ADDR_W > 16 ||
        PAGE_BITS < 1 || PAGE_BITS >= ADDR_W) begin : g_bad_cfg
        $error("sei2c_slave: unsupported address or page width");
    end

    // page-local increment, high bits untouched
    function automatic logic [ADDR_W-1:0] page_inc(
        input logic [ADDR_W-1:0] a
    );
        logic [PAGE_BITS-1:0] low;
        low = a[PAGE_BITS-1:0] + 1'b1;
        return {a[ADDR_W-1:PAGE_BITS], low};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // link domain reset release
    logic lrst1_q;
    logic lrst_n;

    always_ff @(posedge lclk or negedge rstn) begin
        if (!rstn) begin
            lrst1_q <= 1'b0;
            lrst_n <= 1'b0;
        end else begin
            lrst1_q <= 1'b1;
            lrst_n <= lrst1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge history
    logic scl_m_q;
    logic scl_s_q;
    logic scl_p_q;
    logic sda_m_q;
    logic sda_s_q;
    logic sda_p_q;
    logic [1:0] sel_m_q;
    logic [1:0] sel_s_q;

    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            sel_m_q <= 2'h0;
            sel_s_q <= 2'h0;
        end else begin
            scl_m_q <= bus.scl;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= bus.sda;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            sel_m_q <= {select_pin_high, select_pin_low};
            sel_s_q <= sel_m_q;
        end
    end

    // bus events
    logic rise_c;
    logic fall_c;
    logic start_c;
    logic stop_c;

    assign rise_c = scl_s_q & ~scl_p_q;
    assign fall_c = ~scl_s_q & scl_p_q;
    assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    ////////////////////////////////////////////////////////////////////
    // protocol state
    sei2c_pkg::sei2c_sst_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [1:0] nbyte_q;
    logic rd_q;
    logic hdr_q;
    logic mack_q;
    logic sda_oe_q;
    logic [7:0] mem [WORDS]; // storage array
    logic byte_c;
    logic match_c;
    logic mem_we;

    assign byte_c = fall_c & (cnt_q == 4'(`SEI2C_BYTE_BITS));
    // prefix and select compare
    assign match_c = (sh_q[`SEI2C_PFX_HI:`SEI2C_PFX_LO] == DEV_PREFIX)
        & (sh_q[`SEI2C_SEL_HI:`SEI2C_SEL_LO] == sel_s_q);
    assign mem_we = (st_q == sei2c_pkg::S_RX) & byte_c & (nbyte_q == 2'h2);

    // byte sequencing on the serial clock edges
    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            st_q <= sei2c_pkg::S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= '0;
            nbyte_q <= 2'h0;
            rd_q <= 1'b0;
            hdr_q <= 1'b0;
            mack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= sei2c_pkg::S_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_c) begin
            st_q <= sei2c_pkg::S_ADDR;
            cnt_q <= 4'h0;
            nbyte_q <= 2'h0;
            sda_oe_q <= 1'b0;
        end else begin
            // sample on rising clock
            if (rise_c) begin
                if (st_q == sei2c_pkg::S_ADDR || st_q == sei2c_pkg::S_RX) begin
                    sh_q <= {sh_q[6:0], sda_s_q};
                    cnt_q <= cnt_q + 4'h1;
                end
                if (st_q == sei2c_pkg::S_TXACK) begin
                    mack_q <= ~sda_s_q;
                end
            end
            // act on falling clock
            if (fall_c) begin
                unique case (st_q)
                    sei2c_pkg::S_ADDR: begin
                        if (byte_c) begin
                            if (match_c) begin
                                st_q <= sei2c_pkg::S_ACK;
                                sda_oe_q <= 1'b1;
                                rd_q <= sh_q[`SEI2C_RW_BIT];
                                hdr_q <= 1'b1;
                            end else begin
                                st_q <= sei2c_pkg::S_WAITSTOP;
                            end
                        end
                    end
                    sei2c_pkg::S_RX: begin
                        if (byte_c) begin
                            unique case (nbyte_q)
                                2'h0: begin
                                    ptr_q[ADDR_W-1:8] <= sh_q[ADDR_W-9:0];
                                    nbyte_q <= 2'h1;
                                end
                                2'h1: begin
                                    ptr_q[7:0] <= sh_q;
                                    nbyte_q <= 2'h2;
                                end
                                default: begin
                                    ptr_q <= page_inc(ptr_q);
                                end
                            endcase
                            st_q <= sei2c_pkg::S_ACK;
                            sda_oe_q <= 1'b1;
                            hdr_q <= 1'b0;
                        end
                    end
                    sei2c_pkg::S_ACK: begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        if (hdr_q && rd_q) begin
                            st_q <= sei2c_pkg::S_TX;
                            tx_q <= mem[ptr_q];
                            sda_oe_q <= ~mem[ptr_q][7];
                            ptr_q <= ptr_q + 1'b1;
                        end else begin
                            st_q <= sei2c_pkg::S_RX;
                        end
                    end
                    sei2c_pkg::S_TX: begin
                        if (cnt_q == 4'h7) begin
                            sda_oe_q <= 1'b0;
                            st_q <= sei2c_pkg::S_TXACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    sei2c_pkg::S_TXACK: begin
                        cnt_q <= 4'h0;
                        if (mack_q) begin
                            st_q <= sei2c_pkg::S_TX;
                            tx_q <= mem[ptr_q];
                            sda_oe_q <= ~mem[ptr_q][7];
                            ptr_q <= ptr_q + 1'b1;
                        end else begin
                            st_q <= sei2c_pkg::S_WAITSTOP;
                        end
                    end
                    sei2c_pkg::S_IDLE, sei2c_pkg::S_WAITSTOP: begin
                    end
                    default: begin
                        st_q <= sei2c_pkg::S_IDLE;
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // storage write port, no reset on the array
    always_ff @(posedge lclk) begin
        if (mem_we) begin
            mem[ptr_q] <= sh_q;
        end
    end

    // link pin drive, low only
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe = sda_oe_q;

    ////////////////////////////////////////////////////////////////////
    // write event toggle with held word
    logic wr_tgl_q;
    logic [ADDR_W-1:0] hold_addr_q;
    logic [7:0] hold_data_q;

    always_ff @(posedge lclk or negedge lrst_n) begin
        if (!lrst_n) begin
            wr_tgl_q <= 1'b0;
            hold_addr_q <= '0;
            hold_data_q <= 8'h00;
        end else if (mem_we) begin
            wr_tgl_q <= ~wr_tgl_q;
            hold_addr_q <= ptr_q;
            hold_data_q <= sh_q;
        end
    end

    // toggle synchroniser into mclk
    logic tg1_q;
    logic tg2_q;
    logic tg3_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tg1_q <= 1'b0;
            tg2_q <= 1'b0;
            tg3_q <= 1'b0;
        end else begin
            tg1_q <= wr_tgl_q;
            tg2_q <= tg1_q;
            tg3_q <= tg2_q;
        end
    end

    // one-cycle notification, word stable by then
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_valid <= 1'b0;
            wr_addr <= '0;
            wr_data <= 8'h00;
        end else begin
            wr_valid <= tg2_q ^ tg3_q;
            if (tg2_q ^ tg3_q) begin
                wr_addr <= hold_addr_q;
                wr_data <= hold_data_q;
            end
        end
    end
endmodule

// >>> verilog/sei2c_regs.svh
`ifndef SEI2C_REGS_SVH
`define SEI2C_REGS_SVH

////////////////////////////////////////////////////////////////////////
// storage and framing
`define SEI2C_MEM_WORDS 32768
`define SEI2C_ADDR_W 15
`define SEI2C_PAGE_BITS 6
`define SEI2C_PAGE_BYTES 64
`define SEI2C_BYTE_BITS 8
`define SEI2C_ACK_BIT 8
// address byte field positions
`define SEI2C_PFX_HI 7
`define SEI2C_PFX_LO 3
`define SEI2C_SEL_HI 2
`define SEI2C_SEL_LO 1
`define SEI2C_RW_BIT 0

////////////////////////////////////////////////////////////////////////
// timing
`define SEI2C_MCLK_PERIOD_NS 10
`define SEI2C_SCL_PERIOD_NS 10000
`define SEI2C_QTR_CYC (`SEI2C_SCL_PERIOD_NS / (4 * `SEI2C_MCLK_PERIOD_NS))
`endif

// >>> verilog/sei2c_pkg.sv
package sei2c_pkg;
    // device link states
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ADDR = 3'h1,
        S_RX = 3'h2,
        S_ACK = 3'h3,
        S_TX = 3'h4,
        S_TXACK = 3'h5,
        S_WAITSTOP = 3'h6
    } sei2c_sst_t;
    // master bit engine states
    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_HOLD = 3'h1,
        M_START = 3'h2,
        M_BIT = 3'h3,
        M_STOP = 3'h4
    } sei2c_mst_t;
    // master byte commands
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_READ = 2'h1,
        OP_STOP = 2'h2
    } sei2c_op_t;
endpackage

// >>> verilog/sei2c_if.sv
interface sei2c_if;
    logic scl_o;
    logic scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;
    // open-drain lines with pull-up
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
    modport mst (output scl_o, scl_oe, m_sda_o, m_sda_oe, input sda);
    modport dev (input scl, sda, output s_sda_o, s_sda_oe);
endinterface

// >>> verilog/sei2c_master.sv
`include "sei2c_regs.svh"
module sei2c_master #(
    parameter int QTR_CYC = `SEI2C_QTR_CYC
) (
    // system side
    input wire logic mclk,
    input wire logic rstn,
    // link side
    sei2c_if.mst bus,
    // byte command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sei2c_pkg::sei2c_op_t cmd_op,
    input wire logic cmd_start,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ack,
    // byte answer
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);
    if (QTR_CYC < 1 || QTR_CYC > 65535) begin : g_bad_cfg
        $error("sei2c_master: quarter period out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // data pin synchroniser
    logic sda_m_q;
    logic sda_s_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            sda_m_q <= bus.sda;
            sda_s_q <= sda_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bit engine
    sei2c_pkg::sei2c_mst_t st_q;
    sei2c_pkg::sei2c_op_t op_q;
    logic [15:0] qcnt_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic ack_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic tick;
    logic take;

    assign tick = qcnt_q == 16'(QTR_CYC - 1);
    assign take = cmd_valid & cmd_ready;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= sei2c_pkg::M_IDLE;
            op_q <= sei2c_pkg::OP_WRITE;
            qcnt_q <= 16'h0000;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_ack <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            qcnt_q <= tick ? 16'h0000 : qcnt_q + 16'h0001;
            if (take) begin
                cmd_ready <= 1'b0;
                qcnt_q <= 16'h0000;
                ph_q <= 2'h0;
                bit_q <= 4'h0;
                op_q <= cmd_op;
                sh_q <= cmd_data;
                ack_q <= cmd_ack;
                if (cmd_op == sei2c_pkg::OP_STOP) begin
                    if (st_q == sei2c_pkg::M_HOLD) begin
                        st_q <= sei2c_pkg::M_STOP;
                    end else begin
                        rsp_valid <= 1'b1;
                        cmd_ready <= 1'b1;
                    end
                end else if (cmd_start || st_q == sei2c_pkg::M_IDLE) begin
                    st_q <= sei2c_pkg::M_START;
                end else begin
                    st_q <= sei2c_pkg::M_BIT;
                end
            end else if (tick) begin
                ph_q <= ph_q + 2'h1;
                unique case (st_q)
                    sei2c_pkg::M_START: begin
                        // release, clock high, data falls, clock low
                        unique case (ph_q)
                            2'h0: sda_oe_q <= 1'b0;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b1;
                            2'h3: begin
                                scl_oe_q <= 1'b1;
                                st_q <= sei2c_pkg::M_BIT;
                            end
                        endcase
                    end
                    sei2c_pkg::M_BIT: begin
                        unique case (ph_q)
                            2'h0: begin
                                if (bit_q < 4'(`SEI2C_ACK_BIT)) begin
                                    sda_oe_q <= (op_q == sei2c_pkg::OP_WRITE)
                                        & ~sh_q[7];
                                end else begin
                                    sda_oe_q <= (op_q == sei2c_pkg::OP_READ)
                                        & ack_q;
                                end
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: begin
                                if (bit_q < 4'(`SEI2C_ACK_BIT)) begin
                                    sh_q <= {sh_q[6:0], sda_s_q};
                                end else begin
                                    rsp_ack <= ~sda_s_q;
                                end
                            end
                            2'h3: begin
                                scl_oe_q <= 1'b1;
                                if (bit_q == 4'(`SEI2C_ACK_BIT)) begin
                                    sda_oe_q <= 1'b0;
                                    st_q <= sei2c_pkg::M_HOLD;
                                    rsp_valid <= 1'b1;
                                    rsp_data <= sh_q;
                                    cmd_ready <= 1'b1;
                                end else begin
                                    bit_q <= bit_q + 4'h1;
                                end
                            end
                        endcase
                    end
                    sei2c_pkg::M_STOP: begin
                        // data low, clock high, data rises
                        unique case (ph_q)
                            2'h0: sda_oe_q <= 1'b1;
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: sda_oe_q <= 1'b0;
                            2'h3: begin
                                st_q <= sei2c_pkg::M_IDLE;
                                rsp_valid <= 1'b1;
                                cmd_ready <= 1'b1;
                            end
                        endcase
                    end
                    sei2c_pkg::M_IDLE, sei2c_pkg::M_HOLD: begin
                    end
                    default: st_q <= sei2c_pkg::M_IDLE;
                endcase
            end
        end
    end

    // open-drain drive, low only
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = scl_oe_q;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe = sda_oe_q;
endmodule

// >>> bench/sei2c_chk.sv
module sei2c_chk (
    // clocks and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic lclk,
    // open-drain drivers
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    // resolved lines
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic scl_seen_q;
    logic [3:0] low_rise_q;
    ////////////////////////////////////////////////////////////////////////
    // scl level one lclk back
    always_ff @(posedge lclk or negedge rstn) begin
        if (!rstn) scl_seen_q <= 1'b1;
        else scl_seen_q <= scl;
    end
    // scl rises while slave holds sda low
    always_ff @(posedge lclk or negedge rstn) begin
        if (!rstn) low_rise_q <= 4'h0;
        else if (!s_sda_oe) low_rise_q <= 4'h0;
        else if (scl && !scl_seen_q) low_rise_q <= low_rise_q + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    chk_dev_low_only: assert property (
        @(posedge lclk) disable iff (!rstn)
        s_sda_oe |-> (s_sda_o == 1'b0)) else $error("slave drives sda high");
    chk_dev_drive_low: assert property (
        @(posedge lclk) disable iff (!rstn)
        $rose(s_sda_oe) |-> !scl) else $error("sda taken while scl high");
    chk_mst_low_only: assert property (
        @(posedge mclk) disable iff (!rstn)
        (scl_oe || m_sda_oe) |-> (scl_o == 1'b0 && m_sda_o == 1'b0))
        else $error("master drives a line high");
    chk_dev_sda_still: assert property (
        @(posedge lclk) disable iff (!rstn)
        (scl && $past(scl)) |-> $stable(s_sda_oe))
        else $error("slave moved sda while scl high");
    chk_low_span: assert property (
        @(posedge lclk) disable iff (!rstn)
        low_rise_q <= 4'h9) else $error("slave held sda over nine bits");
    chk_no_contend: assert property (
        @(posedge mclk) disable iff (!rstn)
        scl |-> !(s_sda_oe && m_sda_oe)) else $error("both ends drive sda");
    chk_scl_high_len: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(scl) |-> scl [*8]) else $error("scl high phase too short");
    chk_start_then_low: assert property (
        @(posedge mclk) disable iff (!rstn)
        ($fell(sda) && scl) |-> ##[1:24] !scl) else $error("start not closed");
    chk_stop_idle: assert property (
        @(posedge mclk) disable iff (!rstn)
        ($rose(sda) && scl) |-> (sda && scl) [*8])
        else $error("stop not idle");
endmodule

// >>> bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [4:0] PFX = 5'h0b; // arbitrary value
    logic mclk, lclk, rstn, cmd_valid, cmd_start, cmd_ack, cmd_ready;
    logic rsp_valid, rsp_ack, wr_valid, got_a;
    logic [1:0] strap;
    logic [7:0] cmd_data, rsp_data, wr_data, got_d;
    logic [14:0] wr_addr;
    logic [31:0] rng = 32'h98ca;
    sei2c_pkg::sei2c_op_t cmd_op;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] model_mem [int];
    logic [22:0] wr_exp [$];
    ////////////////////////////////////////////////////////////////////////
    sei2c_if bus_if ();
    sei2c_master #(.QTR_CYC(8)) sei2c_master_inst (.mclk(mclk), .rstn(rstn),
        .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_start(cmd_start), .cmd_data(cmd_data),
        .cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ack(rsp_ack));
    sei2c_slave #(.DEV_PREFIX(PFX)) sei2c_slave_inst (.mclk(mclk),
        .rstn(rstn), .lclk(lclk), .bus(bus_if),
        .select_pin_high(strap[1]), .select_pin_low(strap[0]),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
    sei2c_chk sei2c_chk_inst (.mclk(mclk), .rstn(rstn), .lclk(lclk),
        .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe),
        .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
        .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));
    ////////////////////////////////////////////////////////////////////////
    // system and link clocks, unrelated phase
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        lclk = 1'b0;
        #3.3;
        forever #7.5 lclk = ~lclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // xorshift source
    function automatic void next_rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
    endfunction
    // compare tasks
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [22:0] got, input logic [22:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one byte command, held until taken, then wait for the answer
    task automatic do_cmd(input sei2c_pkg::sei2c_op_t op, input logic st,
        input logic [7:0] d, input logic ak);
        int n;
        n = 0;
        cmd_op = op;
        cmd_start = st;
        cmd_data = d;
        cmd_ack = ak;
        cmd_valid = 1'b1;
        do @(posedge mclk); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= 2000) n_mismatch++;
        got_d = rsp_data;
        got_a = rsp_ack;
    endtask
    // address phase of a write: device byte, high then low location
    task automatic set_ptr(input logic [15:0] a);
        do_cmd(sei2c_pkg::OP_WRITE, 1'b1, {PFX, strap, 1'b0}, 1'b0);
        cmp_bit(got_a, 1'b1);
        do_cmd(sei2c_pkg::OP_WRITE, 1'b0, a[15:8], 1'b0);
        cmp_bit(got_a, 1'b1);
        do_cmd(sei2c_pkg::OP_WRITE, 1'b0, a[7:0], 1'b0);
        cmp_bit(got_a, 1'b1);
    endtask
    // page write of n random bytes
    task automatic wr_seq(input logic [15:0] a, input int n);
        logic [14:0] p;
        p = a[14:0];
        set_ptr(a);
        for (int i = 0; i < n; i++) begin
            next_rnd();
            model_mem[p] = rng[7:0];
            wr_exp.push_back({p, rng[7:0]});
            do_cmd(sei2c_pkg::OP_WRITE, 1'b0, rng[7:0], 1'b0);
            cmp_bit(got_a, 1'b1);
            p[5:0] = p[5:0] + 6'h01;
        end
        do_cmd(sei2c_pkg::OP_STOP, 1'b0, 8'h00, 1'b0);
    endtask
    // random read of n bytes, then one read past the nack
    task automatic rd_seq(input logic [15:0] a, input int n);
        logic [14:0] p;
        p = a[14:0];
        set_ptr(a);
        do_cmd(sei2c_pkg::OP_WRITE, 1'b1, {PFX, strap, 1'b1}, 1'b0);
        cmp_bit(got_a, 1'b1);
        for (int i = 0; i < n; i++) begin
            do_cmd(sei2c_pkg::OP_READ, 1'b0, 8'h00, i < n - 1);
            cmp_val({15'h0, got_d}, {15'h0, model_mem[p]});
            p = p + 15'h1;
        end
        do_cmd(sei2c_pkg::OP_READ, 1'b0, 8'h00, 1'b0);
        cmp_val({15'h0, got_d}, 23'h0000ff);
        do_cmd(sei2c_pkg::OP_STOP, 1'b0, 8'h00, 1'b0);
    endtask
    // write notices against the model
    always @(posedge mclk) begin
        if (wr_valid === 1'b1 && wr_exp.size() > 0)
            cmp_val({wr_addr, wr_data}, wr_exp.pop_front());
        else if (wr_valid === 1'b1)
            cmp_val({wr_addr, wr_data}, ~{wr_addr, wr_data});
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (wr_exp.size() != 0) n_mismatch++;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #600000;
        n_mismatch++;
        complete_run();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = sei2c_pkg::OP_WRITE;
        cmd_start = 1'b0;
        cmd_data = 8'h00;
        cmd_ack = 1'b0;
        next_rnd();
        strap = rng[1:0];
        repeat (2) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        for (int s = 0; s < 5; s++) begin
            do_cmd(sei2c_pkg::OP_WRITE, 1'b1,
                {(s == 4) ? ~PFX : PFX, s[1:0], 1'b0}, 1'b0);
            cmp_bit(got_a, s == 4 ? 1'b0 : s[1:0] == strap);
            do_cmd(sei2c_pkg::OP_STOP, 1'b0, 8'h00, 1'b0);
        end
        $display("address select test done");
        wr_seq(16'hc33c, 64);
        wr_seq(16'h4340, 2);
        $display("page write test done");
        rd_seq(16'hc33e, 4);
        $display("sequential read test done");
        complete_run();
    end
endmodule
